//--- frame_start_gate.sv
/*
 * Raw-mode frame start qualifier for one link receiver.
 * Assumes frame_valid_i is sampled once per link clock period, which is
 * represented here by the strobe tick_i on the system clock.
 */
`timescale 1ns/10ps
module frame_start_gate #(
    parameter int CNT_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             raw_mode_i,
    input  wire logic             tick_i,
    input  wire logic             frame_valid_i,
    input  wire logic [CNT_W-1:0] min_periods_i,
    output logic                  frame_start_o
);

    if (CNT_W < 1) begin : g_bad
        $error("CNT_W must be at least 1");
    end

    logic [CNT_W-1:0] count_reg, count_next;
    logic             fired_reg, fired_next;
    logic             start_reg, start_next;

    always_comb begin
        count_next = count_reg;
        fired_next = fired_reg;
        start_next = 1'b0;
        if (!raw_mode_i || !frame_valid_i) begin
            count_next = '0;
            fired_next = 1'b0;
        end else if (tick_i && !fired_reg) begin
            // One start per frame, only after the full minimum hold
            if (count_reg >= min_periods_i) begin
                start_next = 1'b1;
                fired_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
            fired_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            fired_reg <= fired_next;
            start_reg <= start_next;
        end
    end

    assign frame_start_o = start_reg;

endmodule : frame_start_gate

//--- link_misc_control_registers.sv
/*
 * Link miscellaneous control register bank: encoder CRC check control,
 * raw-mode frame valid minimum time and GPIO pull-down control.
 * Assumes an upstream I2C slave that turns bus transactions into one-cycle
 * read and write strobes with address and data, synchronous to SYS_CLK_I.
 */
`timescale 1ns/10ps
module link_misc_control_registers #(
    parameter int NUM_GPIO = link_misc_pkg::GPIO_COUNT
) (
    input  wire logic                      SYS_CLK_I,
    input  wire logic                      RESET_I,
    // Register port from the I2C slave
    input  wire logic                      REG_WR_I,
    input  wire logic                      REG_RD_I,
    input  wire logic [7:0]                REG_ADDR_I,
    input  wire logic [7:0]                REG_WDATA_I,
    output logic      [7:0]                REG_RDATA_O,
    output logic                           REG_RVALID_O,
    // Encoded link-information packets
    input  wire logic                      PKT_VALID_I,
    input  wire logic                      PKT_CRC_OK_I,
    input  wire logic [7:0]                PKT_INFO_I,
    output logic      [7:0]                LINK_INFO_O,
    // Raw-mode frame start
    input  wire logic                      RAW_MODE_I,
    input  wire logic                      LINK_TICK_I,
    input  wire logic                      FRAME_VALID_I,
    output logic                           FRAME_START_O,
    // GPIO pad control
    input  wire logic [NUM_GPIO-1:0]       GPIO_OUT_MODE_I,
    output logic      [NUM_GPIO-1:0]       GPIO_PULLDOWN_EN_O
);

    if (NUM_GPIO != link_misc_pkg::GPIO_COUNT) begin : g_bad
        $error("NUM_GPIO must match the byte-wide pull-down register");
    end

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    link_misc_pkg::reg_req_t  req;
    link_misc_pkg::link_pkt_t pkt;

    assign req = '{wr: REG_WR_I, rd: REG_RD_I,
                   addr: REG_ADDR_I, wdata: REG_WDATA_I};

    // Full-address match; reserved and unmapped offsets never hit
    function automatic logic wr_hit(
        input link_misc_pkg::reg_req_t r,
        input logic [7:0]              addr
    );
        return r.wr && (r.addr == addr);
    endfunction : wr_hit

    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input logic       enc,
        input logic [7:0] fvm,
        input logic [7:0] pdc
    );
        logic [7:0] v;
        v = link_misc_pkg::UNMAPPED_VAL;
        case (addr)
            link_misc_pkg::ENC_CTL_ADDR: v = {enc, link_misc_pkg::ENC_LOW_RSVD};
            link_misc_pkg::RSVD_BB_ADDR: v = link_misc_pkg::RSVD_BB_VAL;
            link_misc_pkg::FV_MIN_ADDR:  v = fvm;
            link_misc_pkg::RSVD_BD_ADDR: v = link_misc_pkg::RSVD_BD_VAL;
            link_misc_pkg::PD_CTL_ADDR:  v = pdc;
            link_misc_pkg::RSVD_BF_ADDR: v = link_misc_pkg::RSVD_BF_VAL;
            default:                     v = link_misc_pkg::UNMAPPED_VAL;
        endcase
        return v;
    endfunction : read_mux

    // ------------------------------------------------------------------
    // Encoder CRC check control
    // ------------------------------------------------------------------
    logic enc_check_reg, enc_check_next;

    always_comb begin
        enc_check_next = enc_check_reg;
        // Only bit 7 is writable; the low bits stay fixed
        if (wr_hit(req, link_misc_pkg::ENC_CTL_ADDR)) begin
            enc_check_next =
                req.wdata[link_misc_pkg::ENC_CHECK_BIT];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            enc_check_reg <= link_misc_pkg::ENC_CHECK_RST;
        end else begin
            enc_check_reg <= enc_check_next;
        end
    end

    // ------------------------------------------------------------------
    // Frame valid minimum time
    // ------------------------------------------------------------------
    logic [7:0] fv_min_reg, fv_min_next;

    always_comb begin
        fv_min_next = fv_min_reg;
        if (wr_hit(req, link_misc_pkg::FV_MIN_ADDR)) begin
            fv_min_next = req.wdata;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            fv_min_reg <= link_misc_pkg::FV_MIN_RST;
        end else begin
            fv_min_reg <= fv_min_next;
        end
    end

    // ------------------------------------------------------------------
    // Pull-down disable bits
    // ------------------------------------------------------------------
    logic [7:0] pd_ctl_reg, pd_ctl_next;

    always_comb begin
        pd_ctl_next = pd_ctl_reg;
        if (wr_hit(req, link_misc_pkg::PD_CTL_ADDR)) begin
            pd_ctl_next = req.wdata;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pd_ctl_reg <= link_misc_pkg::PD_CTL_RST;
        end else begin
            pd_ctl_reg <= pd_ctl_next;
        end
    end

    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------
    logic [7:0] rdata_reg, rdata_next;
    logic       rvalid_reg, rvalid_next;

    always_comb begin
        rdata_next  = rdata_reg;
        rvalid_next = 1'b0;
        // Reserved offsets read fixed values; their writes never hit above
        if (req.rd) begin
            rdata_next  = read_mux(req.addr, enc_check_reg, fv_min_reg,
                                   pd_ctl_reg);
            rvalid_next = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------------
    // Link information update
    // ------------------------------------------------------------------
    logic [7:0] info_reg, info_next;

    assign pkt = '{valid: PKT_VALID_I, crc_ok: PKT_CRC_OK_I,
                   info: PKT_INFO_I};

    always_comb begin
        info_next = info_reg;
        // A clear check bit means checking is on; bad packets are dropped
        if (pkt.valid && (enc_check_reg || pkt.crc_ok)) begin
            info_next = pkt.info;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            info_reg <= 8'h00;
        end else begin
            info_reg <= info_next;
        end
    end

    // ------------------------------------------------------------------
    // Pull-down control
    // ------------------------------------------------------------------
    logic [NUM_GPIO-1:0] pd_en_reg, pd_en_next;

    always_comb begin
        pd_en_next = '0;
        for (int n = 0; n < NUM_GPIO; n++) begin
            // Output mode always removes the pull-down to avoid fighting it
            pd_en_next[n] = !GPIO_OUT_MODE_I[n] && !pd_ctl_reg[n];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pd_en_reg <= '0;
        end else begin
            pd_en_reg <= pd_en_next;
        end
    end

    // ------------------------------------------------------------------
    // Frame start gate
    // ------------------------------------------------------------------
    frame_start_gate #(
        .CNT_W         (8)
    ) u_fs_gate (
        .clk_i         (SYS_CLK_I),
        .rst_i         (RESET_I),
        .raw_mode_i    (RAW_MODE_I),
        .tick_i        (LINK_TICK_I),
        .frame_valid_i (FRAME_VALID_I),
        .min_periods_i (fv_min_reg),
        .frame_start_o (FRAME_START_O)
    );

    assign REG_RDATA_O        = rdata_reg;
    assign REG_RVALID_O       = rvalid_reg;
    assign LINK_INFO_O        = info_reg;
    assign GPIO_PULLDOWN_EN_O = pd_en_reg;

endmodule : link_misc_control_registers

//--- link_misc_control_registers_props.sv
/* Port checker for the link control register bank.
   Assumes a bind to the bank and its synchronous active-high reset. */
`timescale 1ns/10ps
module link_misc_control_registers_props #(
    parameter int NUM_GPIO = 8
) (
    input wire logic                SYS_CLK_I,
    input wire logic                RESET_I,
    input wire logic                REG_WR_I,
    input wire logic                REG_RD_I,
    input wire logic [7:0]          REG_ADDR_I,
    input wire logic [7:0]          REG_WDATA_I,
    input wire logic [7:0]          REG_RDATA_O,
    input wire logic                REG_RVALID_O,
    input wire logic                PKT_VALID_I,
    input wire logic                PKT_CRC_OK_I,
    input wire logic [7:0]          PKT_INFO_I,
    input wire logic [7:0]          LINK_INFO_O,
    input wire logic                RAW_MODE_I,
    input wire logic                LINK_TICK_I,
    input wire logic                FRAME_VALID_I,
    input wire logic                FRAME_START_O,
    input wire logic [NUM_GPIO-1:0] GPIO_OUT_MODE_I,
    input wire logic [NUM_GPIO-1:0] GPIO_PULLDOWN_EN_O
);
    logic                enc_reg;
    logic [NUM_GPIO-1:0] pd_reg;
    // Shadow of the encoder check and pull-down control bits, rebuilt from the write strobes
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            enc_reg <= 1'b1;
            pd_reg  <= '0;
        end else if (REG_WR_I && REG_ADDR_I == 8'hba) begin
            enc_reg <= REG_WDATA_I[7];
        end else if (REG_WR_I && REG_ADDR_I == 8'hbe) begin
            pd_reg <= REG_WDATA_I[NUM_GPIO-1:0];
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    chk_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
        else $error("read strobe not answered");
    chk_no_answer: assert property (!REG_RD_I |=> !REG_RVALID_O)
        else $error("answer without read");
    chk_enc_read: assert property (REG_RD_I && REG_ADDR_I == 8'hba
        |=> REG_RDATA_O == {$past(enc_reg), 7'h03})
        else $error("encoder control read wrong");
    chk_rsvd_fixed: assert property (REG_RD_I
        && REG_ADDR_I == 8'hbb |=> REG_RDATA_O == 8'h74)
        else $error("reserved location read wrong");
    chk_crc_block: assert property (PKT_VALID_I && !PKT_CRC_OK_I
        && !enc_reg |=> $stable(LINK_INFO_O))
        else $error("failed packet stored");
    chk_pkt_store: assert property (PKT_VALID_I && PKT_CRC_OK_I
        |=> LINK_INFO_O == $past(PKT_INFO_I))
        else $error("good packet not stored");
    chk_pd_follow: assert property (!RESET_I
        |=> GPIO_PULLDOWN_EN_O == (~$past(GPIO_OUT_MODE_I) & ~$past(pd_reg)))
        else $error("pull-down enable wrong");
    chk_start_cause: assert property (FRAME_START_O
        |-> $past(LINK_TICK_I) && $past(RAW_MODE_I) && $past(FRAME_VALID_I))
        else $error("frame start without tick");
    chk_start_pulse: assert property (FRAME_START_O
        |=> !FRAME_START_O)
        else $error("frame start longer than a cycle");
endmodule : link_misc_control_registers_props

bind link_misc_control_registers link_misc_control_registers_props #(
    .NUM_GPIO(NUM_GPIO)
) i_link_misc_control_registers_props (
    .SYS_CLK_I, .RESET_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I,
    .REG_RDATA_O, .REG_RVALID_O, .PKT_VALID_I, .PKT_CRC_OK_I, .PKT_INFO_I,
    .LINK_INFO_O, .RAW_MODE_I, .LINK_TICK_I, .FRAME_VALID_I, .FRAME_START_O,
    .GPIO_OUT_MODE_I, .GPIO_PULLDOWN_EN_O
);

//--- link_misc_pkg.sv
/*
 * Constants, field layouts and carrier types for the link miscellaneous
 * control register bank.
 * Assumes an 8-bit register address and byte-wide data, as seen by the
 * device's I2C register port after the serial protocol has been decoded.
 */
package link_misc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ENC_CTL_ADDR   = 8'hba;
    localparam logic [7:0] RSVD_BB_ADDR   = 8'hbb;
    localparam logic [7:0] FV_MIN_ADDR    = 8'hbc;
    localparam logic [7:0] RSVD_BD_ADDR   = 8'hbd;
    localparam logic [7:0] PD_CTL_ADDR    = 8'hbe;
    localparam logic [7:0] RSVD_BF_ADDR   = 8'hbf;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         ENC_CHECK_BIT  = 7;
    localparam logic       ENC_CHECK_RST  = 1'b1;
    localparam logic [6:0] ENC_LOW_RSVD   = 7'h03;
    localparam logic [7:0] RSVD_BB_VAL    = 8'h74;
    localparam logic [7:0] FV_MIN_RST     = 8'h80;
    localparam logic [7:0] RSVD_BD_VAL    = 8'h00;
    localparam logic [7:0] PD_CTL_RST     = 8'h00;
    localparam logic [7:0] RSVD_BF_VAL    = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL   = 8'h00;
    localparam int         GPIO_COUNT     = 8;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic       crc_ok;
        logic [7:0] info;
    } link_pkt_t;

endpackage : link_misc_pkg

//--- testbench.sv
/* Self-checking bench for the link control register bank.
   Assumes one-cycle read strobes answered on the following cycle. */
`timescale 1ns/10ps
module testbench;
    logic       SYS_CLK_I = 1'b0;
    logic       RESET_I = 1'b1;
    logic       REG_WR_I = 1'b0;
    logic       REG_RD_I = 1'b0;
    logic [7:0] REG_ADDR_I = 8'h00;
    logic [7:0] REG_WDATA_I = 8'h00;
    logic [7:0] REG_RDATA_O, LINK_INFO_O, GPIO_PULLDOWN_EN_O;
    logic       REG_RVALID_O, FRAME_START_O;
    logic       PKT_VALID_I = 1'b0;
    logic       PKT_CRC_OK_I = 1'b0;
    logic [7:0] PKT_INFO_I = 8'h00;
    logic       RAW_MODE_I = 1'b0;
    logic       LINK_TICK_I = 1'b0;
    logic       FRAME_VALID_I = 1'b0;
    logic [7:0] GPIO_OUT_MODE_I = 8'h00;
    int         error_cnt = 0;
    int         comparisons = 0;
    int         cycles = 0;
    logic [7:0] addrs [8] = '{8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
                              8'hb9, 8'hc0};
    logic [7:0] rsts [8] = '{8'h83, 8'h74, 8'h80, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h00};
    logic [7:0] rd, v, m, info;
    int         f, c;

    link_misc_control_registers i_link_misc_control_registers (
        .SYS_CLK_I, .RESET_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I,
        .REG_RDATA_O, .REG_RVALID_O, .PKT_VALID_I, .PKT_CRC_OK_I, .PKT_INFO_I,
        .LINK_INFO_O, .RAW_MODE_I, .LINK_TICK_I, .FRAME_VALID_I,
        .FRAME_START_O, .GPIO_OUT_MODE_I, .GPIO_PULLDOWN_EN_O
    );

    initial begin
        forever #4 SYS_CLK_I = ~SYS_CLK_I;
    end
    // Generous ceiling; the whole sequence needs well under 3000 cycles
    always @(posedge SYS_CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    function automatic logic [7:0] expect_rd(logic [7:0] a, logic [7:0] d);
        case (a)
            8'hba: return {d[7], 7'h03};
            8'hbb: return 8'h74;
            8'hbc, 8'hbe: return d;
            default: return 8'h00;
        endcase
    endfunction : expect_rd

    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    task automatic reg_wr(logic [7:0] a, logic [7:0] d);
        @(posedge SYS_CLK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge SYS_CLK_I);
        REG_WR_I <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(logic [7:0] a, output logic [7:0] d);
        @(posedge SYS_CLK_I);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge SYS_CLK_I);
        REG_RD_I <= 1'b0;
        #1;
        check8("read valid", 8'h01, {7'h00, REG_RVALID_O});
        d = REG_RDATA_O;
    endtask : reg_rd

    task automatic pkt(logic ok, logic [7:0] d);
        @(posedge SYS_CLK_I);
        PKT_VALID_I <= 1'b1;
        PKT_CRC_OK_I <= ok;
        PKT_INFO_I <= d;
        @(posedge SYS_CLK_I);
        PKT_VALID_I <= 1'b0;
        #1;
    endtask : pkt

    // One tick every fourth cycle; start is looked for on the three cycles after each tick
    task automatic frame(logic raw, int ticks, output int fst, output int cnt);
        fst = 0;
        cnt = 0;
        RAW_MODE_I <= raw;
        FRAME_VALID_I <= 1'b1;
        for (int k = 1; k <= ticks; k++) begin
            @(posedge SYS_CLK_I);
            LINK_TICK_I <= 1'b1;
            repeat (3) begin
                @(posedge SYS_CLK_I);
                LINK_TICK_I <= 1'b0;
                #1;
                cnt += int'(FRAME_START_O === 1'b1);
                if (fst == 0 && cnt > 0) fst = k;
            end
        end
        @(posedge SYS_CLK_I);
        FRAME_VALID_I <= 1'b0;
        @(posedge SYS_CLK_I);
    endtask : frame

    task automatic stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    initial begin
        void'($urandom(33178));
        repeat (2) @(posedge SYS_CLK_I);
        RESET_I <= 1'b0;
        foreach (addrs[i]) begin
            reg_rd(addrs[i], rd);
            check8("reset value", rsts[i], rd);
        end
        for (int r = 0; r < 4; r++) begin
            foreach (addrs[i]) begin
                v = (r == 0) ? 8'hff : 8'($urandom);
                reg_wr(addrs[i], v);
                reg_rd(addrs[i], rd);
                m = expect_rd(addrs[i], v);
                check8("readback", m, rd);
            end
        end
        for (int i = 0; i < 16; i++) begin
            v = (i == 0) ? 8'h00 : 8'($urandom);
            m = (i < 2) ? 8'h00 : 8'($urandom);
            reg_wr(8'hbe, v);
            GPIO_OUT_MODE_I <= m;
            repeat (2) @(posedge SYS_CLK_I);
            #1;
            check8("pulldown", ~m & ~v, GPIO_PULLDOWN_EN_O);
        end
        pkt(1'b1, 8'h00);
        info = 8'h00;
        for (int i = 0; i < 16; i++) begin
            v = {i[0], 7'h00};
            m = 8'($urandom);
            reg_wr(8'hba, v);
            pkt(i[1], m);
            info = (v[7] | i[1]) ? m : info;
            check8("link info", info, LINK_INFO_O);
        end
        for (int n = 0; n < 4; n++) begin
            v = (n < 2) ? 8'(n) : 8'($urandom_range(6, 2));
            reg_wr(8'hbc, v);
            frame(1'b1, int'(v) + 3, f, c);
            check8("first start tick", v + 8'h01, 8'(f));
            check8("starts per frame", 8'h01, 8'(c));
        end
        frame(1'b0, 4, f, c);
        check8("starts out of raw", 8'h00, 8'(c));
        stop_test();
    end
endmodule : testbench
